// file: test/frame_transfer_ccd_clocking_tb_top.sv
`default_nettype none
module frame_transfer_ccd_clocking_tb_top
  import ccd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk; // 125 MHz
  logic rst; // Async, active high
  logic pixelReady; // Downstream acceptance
  logic pixelValid, nodeReset, imageCleared, frameStored, lineLoaded;
  logic bloomActive, fieldOdd, overrun;
  logic [1:0] phase;
  logic [WORD_W-1:0] pixelData;
  logic g1, g2, gs, gr, gb; // Gate wires from the generator
  logic [WORD_W-1:0] got[$]; // Words accepted downstream
  int nrCount; // Detection node resets seen
  int nErrors = 0;
  int totalChecks = 0;

  ccd_sensor_core u_dut (
    .ref_clk(ref_clk), .rst(rst), .imageGateOne(g1), .imageGateTwo(g2),
    .storageGate(gs), .serialShiftGate(gr), .bloomingGuardGate(gb),
    .pixelValid(pixelValid), .pixelReady(pixelReady),
    .pixelData(pixelData), .nodeReset(nodeReset),
    .imageCleared(imageCleared), .frameStored(frameStored),
    .lineLoaded(lineLoaded), .bloomActive(bloomActive),
    .fieldOdd(fieldOdd), .overrun(overrun), .phase(phase));

  timing_generator_model u_gen (
    .ref_clk(ref_clk), .imageGateOne(g1), .imageGateTwo(g2),
    .storageGate(gs), .serialShiftGate(gr), .bloomingGuardGate(gb));

  ////////////////////////////////////////////////////////////////////////
  // Clock and downstream monitor
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Collects accepted words and counts node resets
  always @(posedge ref_clk) begin
    if (pixelValid === 1'b1 && pixelReady === 1'b1) got.push_back(pixelData);
    if (nodeReset === 1'b1) nrCount++;
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Verdict, reached from the sequence end or the watchdog
  task automatic finalReport();
    if (nErrors == 0 && totalChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic testClear();
    u_gen.clearImage(CLEAR_PULSES - 1);
    check("cleared early", imageCleared, 0);
    u_gen.clearImage(1);
    check("cleared", imageCleared, 1);
    check("stored by clear", frameStored, 0);
    u_gen.loadLine(); // Nothing stored, so refused
    u_gen.shiftPixel(); // Empty register, so refused
    repeat (6) @(posedge ref_clk);
    check("line w/o frame", lineLoaded, 0);
    check("words w/o line", got.size(), 0);
    check("phase clear", phase, PH_CLEAR);
  endtask

  task automatic testTransfer(input logic oddExp);
    u_gen.transferFrame();
    check("stored", frameStored, 1);
    check("clear dropped", imageCleared, 0);
    check("field", fieldOdd, oddExp);
    check("overrun cleared", overrun, 0);
    check("phase store", phase, PH_STORE);
  endtask

  // Integration: shortest shutter time with guard bursts in blanking
  task automatic testGuard();
    u_gen.expose();
    u_gen.guardBurst();
    check("guard seen", bloomActive, 1);
    check("kept clear", imageCleared, 1);
    check("phase held", phase, PH_CLEAR);
  endtask

  // Reads one full line; poke tries a line load in mid-line
  task automatic readLine(input int ln, input bit poke);
    logic [WORD_W-1:0] w;
    logic [WORD_W-1:0] e;
    got.delete();
    nrCount = 0;
    u_gen.loadLine();
    check("line loaded", lineLoaded, 1);
    check("phase read", phase, PH_READ);
    check("guard reset", bloomActive, 0);
    for (int i = 0; i < SHIFT_PER_LINE; i++) begin
      u_gen.shiftPixel();
      if (poke && i == 100) u_gen.loadLine(); // Must be ignored
    end
    repeat (10) @(posedge ref_clk);
    check("words", got.size(), SHIFT_PER_LINE);
    check("node resets", nrCount, SHIFT_PER_LINE);
    check("line empty", lineLoaded, 0);
    for (int i = 0; i < got.size(); i++) begin
      w = got[i];
      if (i < DUMMY_CELLS) begin
        e = {1'b0, 1'b1, ln[LINE_W-1:0], {COL_W{1'b0}}};
        check("dummy", w[DUMMY_BIT:0], e[DUMMY_BIT:0]);
      end else begin
        e[COL_W-1:0] = COL_W'(i - DUMMY_CELLS);
        e[LINE_LSB+:LINE_W] = ln[LINE_W-1:0];
        e[DUMMY_BIT] = 1'b0;
        e[DARK_BIT] = (i - DUMMY_CELLS) < DARK_COLS;
        check("pixel", w, e);
      end
    end
  endtask

  // Stalls downstream until the buffer refuses, then drains it
  task automatic testOverrun(input int ln);
    got.delete();
    pixelReady <= 1'b0;
    u_gen.loadLine();
    repeat (FIFO_DEPTH + 8) u_gen.shiftPixel();
    check("overrun", overrun, 1);
    check("held valid", pixelValid, 1);
    @(posedge ref_clk) pixelReady <= 1'b1;
    repeat (FIFO_DEPTH + 8) @(posedge ref_clk);
    // Output register holds one word beyond the buffer array
    check("drained", got.size(), FIFO_DEPTH + 1);
    check("empty valid", pixelValid, 0);
    check("first kept", got[0][DUMMY_BIT:LINE_LSB], {1'b1, ln[7:0]});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1;
    pixelReady = 1'b1;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check("reset flags", {imageCleared, frameStored, lineLoaded, bloomActive,
          fieldOdd, overrun, pixelValid, nodeReset}, 0);
    check("reset phase", phase, PH_IDLE);
    testClear();
    testGuard();
    testTransfer(1'b1);
    readLine(0, 1'b0);
    readLine(1, 1'b1);
    testOverrun(2);
    testTransfer(1'b0);
    finalReport();
  end

  // Watchdog sized well above the run of about 16k cycles
  initial begin
    repeat (90000) @(posedge ref_clk);
    nErrors++;
    finalReport();
  end
endmodule // frame_transfer_ccd_clocking_tb_top
`default_nettype wire

// file: test/timing_generator_model.sv
`default_nettype none
module timing_generator_model
  import ccd_pkg::*;
(
  input wire logic ref_clk,
  output logic imageGateOne,
  output logic imageGateTwo,
  output logic storageGate,
  output logic serialShiftGate,
  output logic bloomingGuardGate
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////
  // Gate levels, all parked low between pulses
  logic [PIN_COUNT-1:0] pins = '0;

  assign imageGateOne = pins[PIN_IMG1];
  assign imageGateTwo = pins[PIN_IMG2];
  assign storageGate = pins[PIN_STORE];
  assign serialShiftGate = pins[PIN_SERIAL];
  assign bloomingGuardGate = pins[PIN_BLOOM];

  ////////////////////////////////////////////////////////////////////////
  // One pulse on the masked gates; 4 cycles high and 4 low so the
  // sensor's synchronisers always see a clean edge
  task automatic pulse(input logic [PIN_COUNT-1:0] mask);
    @(posedge ref_clk) pins <= mask;
    repeat (4) @(posedge ref_clk);
    pins <= '0;
    repeat (4) @(posedge ref_clk);
  endtask

  // Clear: both image gates, storage left alone
  task automatic clearImage(input int n);
    repeat (n) pulse(5'h03);
  endtask

  // Frame transfer: image and storage clocked together per line
  task automatic transferFrame();
    repeat (STORE_LINES) pulse(5'h07);
  endtask

  // Guard burst in a blanking gap while integrating
  task automatic guardBurst();
    repeat (3) pulse(5'h10);
  endtask

  // One line from storage into the serial register
  task automatic loadLine();
    pulse(5'h04);
  endtask

  // Shortest shutter time, 1/50000 s counted in 8 ns clock periods
  localparam int SHUTTER_MIN = 2500;

  // Integration between a shutter clear and the frame transfer
  task automatic expose();
    repeat (SHUTTER_MIN) @(posedge ref_clk);
  endtask

  // One serial shift, never overlapping a line load; logic level only,
  // the third gate level for correlated sampling is the driver's
  task automatic shiftPixel();
    pulse(5'h08);
  endtask
endmodule // timing_generator_model
`default_nettype wire

// file: verilog/ccd_pkg.sv
`default_nettype none
package ccd_pkg;
  // Array geometry
  localparam int LINES = 243; // Lines in the sensing area
  localparam int ELEMENTS = 336; // Elements per line
  localparam int DARK_COLS = 12; // Shielded columns on the left edge
  localparam int EXTRA_COLS = 1; // Spare column on the right edge
  localparam int EXTRA_LINES = 1; // Spare line next to the clear line
  localparam int DUMMY_CELLS = 2; // Cells before the detection node
  localparam int CLEAR_PULSES = 244; // Image gate pulses for a full clear
  // Derived counts
  localparam int STORE_LINES = LINES + EXTRA_LINES;
  localparam int SHIFT_PER_LINE = DUMMY_CELLS + ELEMENTS + EXTRA_COLS;
  // Field widths
  localparam int COL_W = 9;
  localparam int LINE_W = 8;
  localparam int CNT_W = 9;
  localparam int WORD_W = COL_W + LINE_W + 2;
  // Pixel word layout
  localparam int DARK_BIT = WORD_W - 1;
  localparam int DUMMY_BIT = WORD_W - 2;
  localparam int LINE_LSB = COL_W;
  // Output buffering
  localparam int FIFO_DEPTH = 32;
  // Pin vector bit positions
  localparam int PIN_IMG1 = 0;
  localparam int PIN_IMG2 = 1;
  localparam int PIN_STORE = 2;
  localparam int PIN_SERIAL = 3;
  localparam int PIN_BLOOM = 4;
  localparam int PIN_COUNT = 5;
  // Operating phase as seen from the gate activity
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_CLEAR = 2'b01,
    PH_STORE = 2'b10,
    PH_READ = 2'b11
  } phase_e;
endpackage
`default_nettype wire

// file: verilog/ccd_sensor_core.sv
`default_nettype none
module ccd_sensor_core
  import ccd_pkg::*;
#(
  parameter int LINE_COUNT = LINES,
  parameter int ELEMENT_COUNT = ELEMENTS,
  parameter int FIFO_WORDS = FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic imageGateOne,
  input wire logic imageGateTwo,
  input wire logic storageGate,
  input wire logic serialShiftGate,
  input wire logic bloomingGuardGate,
  output logic pixelValid,
  input wire logic pixelReady,
  output logic [WORD_W-1:0] pixelData,
  output logic nodeReset,
  output logic imageCleared,
  output logic frameStored,
  output logic lineLoaded,
  output logic bloomActive,
  output logic fieldOdd,
  output logic overrun,
  output logic [1:0] phase
);
  initial begin
    if (LINE_COUNT + EXTRA_LINES >= (1 << CNT_W) ||
        ELEMENT_COUNT + DUMMY_CELLS + EXTRA_COLS >= (1 << CNT_W) ||
        LINE_COUNT >= (1 << LINE_W) || ELEMENT_COUNT <= DARK_COLS)
      $error("ccd_sensor_core: geometry does not fit counters");
  end

  localparam logic [CNT_W-1:0] STORE_MAX = CNT_W'(LINE_COUNT + EXTRA_LINES);
  localparam logic [CNT_W-1:0] SHIFT_MAX =
    CNT_W'(ELEMENT_COUNT + DUMMY_CELLS + EXTRA_COLS);
  localparam logic [CNT_W-1:0] CLEAR_MAX = CNT_W'(CLEAR_PULSES);
  localparam logic [LINE_W-1:0] LAST_LINE = LINE_W'(LINE_COUNT - 1);
  localparam logic [COL_W-1:0] DARK_LIMIT = COL_W'(DARK_COLS);
  localparam logic [CNT_W-1:0] DUMMY_EDGE =
    CNT_W'(ELEMENT_COUNT + EXTRA_COLS);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; gate clocks come from an external generator
  logic [PIN_COUNT-1:0] pinsA_q; // First stage, read only by stage two
  logic [PIN_COUNT-1:0] pinsB_q; // Settled pin levels
  logic [PIN_COUNT-1:0] pinsC_q; // Previous settled levels
  logic [PIN_COUNT-1:0] rise; // Rising edges of settled levels

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pinsA_q <= '0;
      pinsB_q <= '0;
      pinsC_q <= '0;
    end else begin
      pinsA_q <= {bloomingGuardGate, serialShiftGate, storageGate,
                  imageGateTwo, imageGateOne};
      pinsB_q <= pinsA_q;
      pinsC_q <= pinsB_q;
    end
  end

  assign rise = pinsB_q & ~pinsC_q;

  ////////////////////////////////////////////////////////////////////////
  // Gate activity decode
  logic imgPulse; // Image area clocked by either gate
  logic clearPulse; // Image clocked, storage idle
  logic xferPulse; // Image and storage clocked together
  logic lineLoad; // Storage alone moves a line to serial
  logic shiftPulse; // Serial register shifts one cell

  logic [CNT_W-1:0] clearCnt_q; // Clear pulses since the last transfer pulse, saturating
  logic [CNT_W-1:0] storedCnt_q; // Lines moved into storage
  logic frameStored_q; // Full image sits in storage
  logic [LINE_W-1:0] lineIdx_q; // Next storage line to read
  logic [CNT_W-1:0] shiftLeft_q; // Cells still in serial register
  logic imageCleared_q; // Image area fully cleared
  logic fieldOdd_q; // Interlace field parity
  logic nodeReset_q; // Detection node reset strobe
  logic bloomActive_q; // Guard gate pulsed this line
  logic overrun_q; // A pixel found the buffer full
  phase_e phase_q; // Current operating phase

  assign imgPulse = rise[PIN_IMG1] | rise[PIN_IMG2];
  assign clearPulse = imgPulse & ~rise[PIN_STORE];
  assign xferPulse = imgPulse & rise[PIN_STORE];
  // Readout waits for a stored frame and an empty register
  assign lineLoad = rise[PIN_STORE] & ~imgPulse & frameStored_q &
                    (shiftLeft_q == '0);
  assign shiftPulse = rise[PIN_SERIAL] & (shiftLeft_q != '0);

  ////////////////////////////////////////////////////////////////////////
  // Clear through the clear line; charge is thrown away here
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      clearCnt_q <= '0;
      imageCleared_q <= 1'b0;
    end else if (clearPulse) begin
      if (clearCnt_q != CLEAR_MAX) clearCnt_q <= clearCnt_q + 1'b1;
      if (clearCnt_q == CLEAR_MAX - 1'b1) imageCleared_q <= 1'b1;
    end else if (xferPulse) begin
      // New image leaves the area; a fresh clear is needed again
      clearCnt_q <= '0;
      imageCleared_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame transfer into storage, counting the spare line too
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      storedCnt_q <= '0;
      frameStored_q <= 1'b0;
      fieldOdd_q <= 1'b0;
    end else if (xferPulse) begin
      if (storedCnt_q == STORE_MAX - 1'b1) begin
        storedCnt_q <= '0;
        frameStored_q <= 1'b1;
        fieldOdd_q <= ~fieldOdd_q;
      end else begin
        storedCnt_q <= storedCnt_q + 1'b1;
        frameStored_q <= 1'b0;
      end
    end else if (lineLoad && lineIdx_q == LAST_LINE) begin
      frameStored_q <= 1'b0; // Last line handed to serial
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Line transfer from storage into the serial register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lineIdx_q <= '0;
    end else if (xferPulse) begin
      lineIdx_q <= '0;
    end else if (lineLoad) begin
      lineIdx_q <= (lineIdx_q == LAST_LINE) ? '0 : lineIdx_q + 1'b1;
    end
  end

  // Serial register fill level, dummies and spare column included
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shiftLeft_q <= '0;
    end else if (lineLoad) begin
      shiftLeft_q <= SHIFT_MAX;
    end else if (shiftPulse) begin
      shiftLeft_q <= shiftLeft_q - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pixel word for each shifted cell
  logic [LINE_W-1:0] curLine_q; // Line now in the serial register
  logic isDummy; // Cell is one of the dummy cells
  logic [COL_W-1:0] colIdx; // Column of the cell leaving
  logic [WORD_W-1:0] pushData; // Word into the buffer
  logic pushReady; // Buffer can take a word

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      curLine_q <= '0;
    end else if (lineLoad) begin
      curLine_q <= lineIdx_q;
    end
  end

  // Dummy cells leave first, then columns from the left edge
  assign isDummy = shiftLeft_q > DUMMY_EDGE;
  assign colIdx = isDummy ? '0 : COL_W'(DUMMY_EDGE - shiftLeft_q);
  assign pushData = {~isDummy && (colIdx < DARK_LIMIT), isDummy,
                     curLine_q, colIdx};

  // Sensor cannot stall its charge; a full buffer loses the pixel
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      overrun_q <= 1'b0;
    end else if (shiftPulse && !pushReady) begin
      overrun_q <= 1'b1;
    end else if (xferPulse) begin
      overrun_q <= 1'b0; // New frame starts clean
    end
  end

  pixel_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_WORDS)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .inValid(shiftPulse),
    .inReady(pushReady),
    .inData(pushData),
    .outValid(pixelValid),
    .outReady(pixelReady),
    .outData(pixelData)
  );

  ////////////////////////////////////////////////////////////////////////
  // Detection node reset follows each sensed cell, no reset pin
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      nodeReset_q <= 1'b0;
    end else begin
      nodeReset_q <= shiftPulse;
    end
  end

  // Guard gate activity, cleared at every new line
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bloomActive_q <= 1'b0;
    end else if (rise[PIN_BLOOM]) begin
      bloomActive_q <= 1'b1;
    end else if (rise[PIN_STORE]) begin
      bloomActive_q <= 1'b0;
    end
  end

  // Phase tracker
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase_q <= PH_IDLE;
    end else begin
      case (phase_q)
        PH_IDLE, PH_CLEAR, PH_STORE, PH_READ: begin
          if (clearPulse) phase_q <= PH_CLEAR;
          else if (xferPulse) phase_q <= PH_STORE;
          else if (lineLoad) phase_q <= PH_READ;
        end
        default: phase_q <= PH_IDLE;
      endcase
    end
  end

  assign nodeReset = nodeReset_q;
  assign imageCleared = imageCleared_q;
  assign frameStored = frameStored_q;
  assign lineLoaded = (shiftLeft_q != '0);
  assign bloomActive = bloomActive_q;
  assign fieldOdd = fieldOdd_q;
  assign overrun = overrun_q;
  assign phase = phase_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_load;
    lineLoad;
  endsequence
  sequence s_shift_done;
    shiftPulse ##1 nodeReset_q;
  endsequence

  AST_STORE_BOUND: assert property (storedCnt_q < STORE_MAX)
    else $error("stored line count past array height");
  AST_DARK_REF: assert property (
    shiftPulse && !isDummy && colIdx < DARK_LIMIT |-> pushData[DARK_BIT])
    else $error("dark column not flagged");
  AST_SHIFT_LOAD: assert property (
    s_load |=> shiftLeft_q == SHIFT_MAX)
    else $error("serial load count wrong");
  AST_CLEAR_DISCARD: assert property (
    clearPulse |=> $stable(storedCnt_q) && $stable(frameStored_q))
    else $error("cleared charge reached storage");
  AST_FRAME_FIRST: assert property (s_load |-> frameStored_q)
    else $error("line read before frame stored");
  AST_NODE_RESET: assert property (shiftPulse |-> s_shift_done)
    else $error("node reset strobe misplaced");
  AST_DUMMY_FIRST: assert property (
    shiftPulse && shiftLeft_q == SHIFT_MAX |->
    isDummy && pushData[DUMMY_BIT])
    else $error("first shifted cell not a dummy");
endmodule // ccd_sensor_core
`default_nettype wire

// file: verilog/pixel_fifo.sv
`default_nettype none
module pixel_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("pixel_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH]; // Storage array
  logic [AW-1:0] wrPtr_q; // Write pointer
  logic [AW-1:0] rdPtr_q; // Read pointer
  logic [AW:0] count_q; // Words held in the array
  logic outValid_q; // Output register holds a word
  logic [WIDTH-1:0] outData_q; // Output register
  logic push; // Word accepted
  logic pop; // Word moved into the output register

  ////////////////////////////////////////////////////////////////////////
  // Handshakes; the output register counts as one extra slot
  assign inReady = (count_q != (AW+1)'(DEPTH));
  assign push = inValid && inReady;
  assign pop = (count_q != '0) && (!outValid_q || outReady);
  assign outValid = outValid_q;
  assign outData = outData_q;

  // Array writes, no reset needed on data
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  // Pointers and fill level
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) wrPtr_q <= wrPtr_q + 1'b1;
      if (pop) rdPtr_q <= rdPtr_q + 1'b1;
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Registered read data
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      outValid_q <= 1'b0;
      outData_q <= '0;
    end else if (pop) begin
      outValid_q <= 1'b1;
      outData_q <= mem[rdPtr_q];
    end else if (outReady) begin
      outValid_q <= 1'b0;
    end
  end
endmodule // pixel_fifo
`default_nettype wire
